// ### single_wire_uart_slave_port.sv
// Single-wire UART register access port, device side.
module single_wire_uart_slave_port #(
    parameter int BIT_W = 16,
    parameter int DEF_BIT = swu_pkg::DEF_BIT_CYCLES,
    parameter int MAX_BIT = swu_pkg::MAX_BIT_CYCLES,
    parameter int FIFO_DEPTH = swu_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic lineTrueIn,
    output logic lineTrueOut,
    output logic lineTrueOe_n,
    output logic lineCompOut,
    output logic lineCompOe_n,
    input wire logic [7:0] nodeAddressSetting,
    input wire logic addressIncrementPin,
    input wire logic [3:0] replyDelaySetting,
    output logic wrValid,
    input wire logic wrReady,
    output logic [6:0] wrAddr,
    output logic [31:0] wrData,
    output logic rdReq,
    output logic [6:0] rdAddr,
    input wire logic [31:0] rdData,
    output logic [7:0] datagramCount
);
    localparam int CW = BIT_W + 7;
    localparam int MAX_MEAS = swu_pkg::MEAS_BITS * MAX_BIT;

    swu_pkg::state_t state_ff, nxt_state;
    logic rxS1_ff, rxS2_ff, rxPrev_ff;
    logic incS1_ff, incS2_ff;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [CW-1:0] gap_ff, nxt_gap;
    logic [BIT_W-1:0] bitTime_ff, nxt_bitTime;
    logic [BIT_W-1:0] lastBit_ff, nxt_lastBit;
    logic [3:0] bitIdx_ff, nxt_bitIdx;
    logic [2:0] byteIdx_ff, nxt_byteIdx;
    logic fall2_ff, nxt_fall2;
    logic [7:0] rxByte_ff, nxt_rxByte;
    logic [7:0] addr_ff, nxt_addr;
    logic [7:0] reg_ff, nxt_reg;
    logic [31:0] data_ff, nxt_data;
    logic [7:0] crc_ff, nxt_crc;
    logic long_ff, nxt_long;
    logic [9:0] txShift_ff, nxt_txShift;
    logic [7:0] count_ff, nxt_count;
    logic rdReq_ff, nxt_rdReq;
    logic [6:0] rdAddr_ff, nxt_rdAddr;

    logic rx, fall, rise, driving, match, crcIdx;
    logic fifoIn, fifoRdy;
    logic [7:0] myAddr;
    logic [CW-1:0] bitW, gapLim, recW, tailW, delayW;
    logic [3:0] delayUnits;

    // Picks the byte that a reply sends at a given position.
    function automatic logic [7:0] txByteSel(input logic [2:0] k, input logic [6:0] ra,
                                             input logic [31:0] d, input logic [7:0] c);
        case (k)
            3'h0: txByteSel = swu_pkg::SYNC_BYTE;
            3'h1: txByteSel = swu_pkg::REPLY_ADDR;
            3'h2: txByteSel = {1'b0, ra};
            3'h3: txByteSel = d[31:24];
            3'h4: txByteSel = d[23:16];
            3'h5: txByteSel = d[15:8];
            3'h6: txByteSel = d[7:0];
            default: txByteSel = c;
        endcase
    endfunction

    // Line edges seen after the two-stage synchroniser.
    assign rx = rxS2_ff;
    assign fall = rxPrev_ff && !rxS2_ff;
    assign rise = !rxPrev_ff && rxS2_ff;

    // Own address; the reply address is never answered.
    assign myAddr = nodeAddressSetting + {7'h00, incS2_ff};
    assign match = (addr_ff == myAddr) && (myAddr != swu_pkg::REPLY_ADDR);

    // Durations in clock cycles derived from the bit times.
    assign bitW = CW'(bitTime_ff);
    assign gapLim = CW'(lastBit_ff) * CW'(swu_pkg::GAP_BITS);
    assign recW = CW'(lastBit_ff) * CW'(swu_pkg::RECOVER_BITS);
    assign tailW = bitW * CW'(swu_pkg::TAIL_BITS);
    assign delayUnits = (replyDelaySetting == 4'h0) ? 4'h1 : replyDelaySetting;
    assign delayW = bitW * CW'(swu_pkg::DELAY_UNIT_BITS) * CW'(delayUnits);
    assign crcIdx = long_ff ? (byteIdx_ff == swu_pkg::LONG_CRC_IDX)
                            : (byteIdx_ff == swu_pkg::SHORT_CRC_IDX);

    // Both pins drive only during a reply and its tail.
    assign driving = (state_ff == swu_pkg::TXBIT) || (state_ff == swu_pkg::TAIL);
    assign lineTrueOut = txShift_ff[0];
    assign lineCompOut = !txShift_ff[0];
    assign lineTrueOe_n = !driving;
    assign lineCompOe_n = !driving;
    assign rdReq = rdReq_ff;
    assign rdAddr = rdAddr_ff;
    assign datagramCount = count_ff;
    assign fifoIn = (state_ff == swu_pkg::PUSH);

    // Accepted writes wait here until the register side takes them.
    swu_fifo #(
        .WIDTH(swu_pkg::FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) wrFifo (
        .clk(clk),
        .rst(rst),
        .inValid(fifoIn),
        .inReady(fifoRdy),
        .inData({reg_ff[6:0], data_ff}),
        .outValid(wrValid),
        .outReady(wrReady),
        .outData({wrAddr, wrData})
    );

    // Next-state logic of receiver, checker and reply transmitter.
    always_comb begin
        logic [2:0] k;
        logic [7:0] b;
        k = byteIdx_ff + 3'h1;
        b = txByteSel(k, reg_ff[6:0], rdData, crc_ff);
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_gap = gap_ff;
        nxt_bitTime = bitTime_ff;
        nxt_lastBit = lastBit_ff;
        nxt_bitIdx = bitIdx_ff;
        nxt_byteIdx = byteIdx_ff;
        nxt_fall2 = fall2_ff;
        nxt_rxByte = rxByte_ff;
        nxt_addr = addr_ff;
        nxt_reg = reg_ff;
        nxt_data = data_ff;
        nxt_crc = crc_ff;
        nxt_long = long_ff;
        nxt_txShift = txShift_ff;
        nxt_count = count_ff;
        nxt_rdReq = 1'b0;
        nxt_rdAddr = rdAddr_ff;
        case (state_ff)
            swu_pkg::IDLE: begin
                if (fall) begin
                    nxt_cnt = CW'(1);
                    nxt_gap = CW'(1);
                    nxt_fall2 = 1'b0;
                    nxt_state = swu_pkg::MEAS;
                end
            end
            swu_pkg::MEAS: begin
                nxt_cnt = cnt_ff + CW'(1);
                nxt_gap = gap_ff + CW'(1);
                if (rise && cnt_ff < CW'(swu_pkg::GLITCH_CYCLES)) begin
                    nxt_cnt = recW;
                    nxt_state = swu_pkg::RECOVER;
                end else if (cnt_ff > CW'(MAX_MEAS)) begin
                    nxt_cnt = recW;
                    nxt_state = swu_pkg::RECOVER;
                end else if (fall && !fall2_ff) begin
                    nxt_fall2 = 1'b1;
                end else if (fall && cnt_ff[CW-1:2] < CW'(swu_pkg::MIN_BIT_CYCLES)) begin
                    nxt_cnt = recW;
                    nxt_state = swu_pkg::RECOVER;
                end else if (fall) begin
                    // Four bit times have passed; sample sync bit 3 at its middle.
                    nxt_bitTime = cnt_ff[BIT_W+1:2];
                    nxt_cnt = CW'(cnt_ff[BIT_W+1:3]);
                    nxt_bitIdx = swu_pkg::SYNC3_IDX;
                    nxt_rxByte = {swu_pkg::SYNC_LOW3, 5'h00};
                    nxt_byteIdx = 3'h0;
                    nxt_crc = 8'h00;
                    nxt_long = 1'b0;
                    nxt_state = swu_pkg::RXBIT;
                end
            end
            swu_pkg::RXBIT: begin
                nxt_gap = gap_ff + CW'(1);
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - CW'(1);
                end else begin
                    nxt_cnt = bitW - CW'(1);
                    nxt_bitIdx = bitIdx_ff + 4'h1;
                    if (bitIdx_ff != swu_pkg::RX_STOP_IDX) begin
                        nxt_rxByte = {rx, rxByte_ff[7:1]};
                    end else if (!rx) begin
                        nxt_cnt = recW;
                        nxt_state = swu_pkg::RECOVER;
                    end else if (crcIdx) begin
                        if (rxByte_ff != crc_ff) begin
                            nxt_cnt = recW;
                            nxt_state = swu_pkg::RECOVER;
                        end else begin
                            nxt_lastBit = bitTime_ff;
                            if (!match) begin
                                nxt_state = swu_pkg::IDLE;
                            end else if (long_ff) begin
                                nxt_state = swu_pkg::PUSH;
                            end else begin
                                nxt_rdReq = 1'b1;
                                nxt_rdAddr = reg_ff[6:0];
                                nxt_cnt = delayW - CW'(1);
                                nxt_state = swu_pkg::DELAY;
                            end
                        end
                    end else begin
                        // Fold the byte into the checksum and file it.
                        nxt_crc = swu_pkg::crcByte(crc_ff, rxByte_ff);
                        nxt_byteIdx = k;
                        nxt_state = swu_pkg::GAP;
                        if (byteIdx_ff == swu_pkg::ADDR_IDX) begin
                            nxt_addr = rxByte_ff;
                        end else if (byteIdx_ff == swu_pkg::REG_IDX) begin
                            nxt_reg = rxByte_ff;
                            // Replies of other slaves are full length too.
                            nxt_long = rxByte_ff[swu_pkg::RW_BIT]
                                       || (addr_ff == swu_pkg::REPLY_ADDR);
                        end else begin
                            nxt_data = {data_ff[23:0], rxByte_ff};
                        end
                    end
                end
            end
            swu_pkg::GAP: begin
                nxt_gap = gap_ff + CW'(1);
                if (gap_ff > gapLim) begin
                    nxt_cnt = recW;
                    nxt_state = swu_pkg::RECOVER;
                end else if (fall) begin
                    nxt_cnt = bitW + (bitW >> 1) - CW'(1);
                    nxt_gap = CW'(1);
                    nxt_bitIdx = 4'h0;
                    nxt_state = swu_pkg::RXBIT;
                end
            end
            swu_pkg::PUSH: begin
                if (fifoRdy) begin
                    nxt_count = count_ff + 8'h01;
                    nxt_state = swu_pkg::IDLE;
                end
            end
            swu_pkg::DELAY: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - CW'(1);
                end else begin
                    // Reply runs on the bit time of the request.
                    nxt_txShift = {1'b1, swu_pkg::SYNC_BYTE, 1'b0};
                    nxt_crc = swu_pkg::crcByte(8'h00, swu_pkg::SYNC_BYTE);
                    nxt_byteIdx = 3'h0;
                    nxt_bitIdx = 4'h0;
                    nxt_cnt = bitW - CW'(1);
                    nxt_state = swu_pkg::TXBIT;
                end
            end
            swu_pkg::TXBIT: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - CW'(1);
                end else begin
                    nxt_cnt = bitW - CW'(1);
                    nxt_txShift = {1'b1, txShift_ff[9:1]};
                    nxt_bitIdx = bitIdx_ff + 4'h1;
                    if (bitIdx_ff == swu_pkg::TX_STOP_IDX) begin
                        nxt_bitIdx = 4'h0;
                        if (byteIdx_ff == swu_pkg::LONG_CRC_IDX) begin
                            nxt_cnt = tailW - CW'(1);
                            nxt_state = swu_pkg::TAIL;
                        end else begin
                            nxt_txShift = {1'b1, b, 1'b0};
                            nxt_crc = swu_pkg::crcByte(crc_ff, b);
                            nxt_byteIdx = k;
                        end
                    end
                end
            end
            swu_pkg::TAIL: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - CW'(1);
                end else begin
                    nxt_state = swu_pkg::IDLE;
                end
            end
            swu_pkg::RECOVER: begin
                // Any low level restarts the idle time.
                if (!rx) begin
                    nxt_cnt = recW;
                end else if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - CW'(1);
                end else begin
                    nxt_state = swu_pkg::IDLE;
                end
            end
            default: begin
                nxt_state = swu_pkg::IDLE;
            end
        endcase
    end

    // State registers and input synchronisers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= swu_pkg::IDLE;
            rxS1_ff <= 1'b1;
            rxS2_ff <= 1'b1;
            rxPrev_ff <= 1'b1;
            incS1_ff <= 1'b0;
            incS2_ff <= 1'b0;
            cnt_ff <= '0;
            gap_ff <= '0;
            bitTime_ff <= BIT_W'(DEF_BIT);
            lastBit_ff <= BIT_W'(DEF_BIT);
            bitIdx_ff <= 4'h0;
            byteIdx_ff <= 3'h0;
            fall2_ff <= 1'b0;
            rxByte_ff <= 8'h00;
            addr_ff <= 8'h00;
            reg_ff <= 8'h00;
            data_ff <= 32'h0000_0000;
            crc_ff <= 8'h00;
            long_ff <= 1'b0;
            txShift_ff <= 10'h3ff;
            count_ff <= 8'h00;
            rdReq_ff <= 1'b0;
            rdAddr_ff <= 7'h00;
        end else begin
            state_ff <= nxt_state;
            rxS1_ff <= lineTrueIn;
            rxS2_ff <= rxS1_ff;
            rxPrev_ff <= rxS2_ff;
            incS1_ff <= addressIncrementPin;
            incS2_ff <= incS1_ff;
            cnt_ff <= nxt_cnt;
            gap_ff <= nxt_gap;
            bitTime_ff <= nxt_bitTime;
            lastBit_ff <= nxt_lastBit;
            bitIdx_ff <= nxt_bitIdx;
            byteIdx_ff <= nxt_byteIdx;
            fall2_ff <= nxt_fall2;
            rxByte_ff <= nxt_rxByte;
            addr_ff <= nxt_addr;
            reg_ff <= nxt_reg;
            data_ff <= nxt_data;
            crc_ff <= nxt_crc;
            long_ff <= nxt_long;
            txShift_ff <= nxt_txShift;
            count_ff <= nxt_count;
            rdReq_ff <= nxt_rdReq;
            rdAddr_ff <= nxt_rdAddr;
        end
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    // A short pulse on the idle line leads to recovery.
    glitch_reject_a: assert property (
        (state_ff == swu_pkg::MEAS && rise && cnt_ff < CW'(swu_pkg::GLITCH_CYCLES))
        |=> state_ff == swu_pkg::RECOVER && cnt_ff == recW)
        else $error("glitch not rejected");

    // The true-line driver is on only while a reply is in flight.
    drive_window_a: assert property (
        !lineTrueOe_n |-> (state_ff == swu_pkg::TXBIT || state_ff == swu_pkg::TAIL))
        else $error("line driven outside a reply");

    // Each accepted write bumps the counter by one.
    count_step_a: assert property (
        (state_ff == swu_pkg::PUSH && fifoRdy) |=> count_ff == $past(count_ff) + 8'h01)
        else $error("write counter did not step");

    // Nothing else moves the counter.
    count_hold_a: assert property (
        !(state_ff == swu_pkg::PUSH && fifoRdy) |=> $stable(count_ff))
        else $error("write counter moved without a write");

    // A long pause between bytes abandons the datagram.
    gap_abandon_a: assert property (
        (state_ff == swu_pkg::GAP && gap_ff > gapLim) |=> state_ff == swu_pkg::RECOVER)
        else $error("byte gap timeout missed");

    // The reply opens with a start bit and then the sync nibble.
    reply_start_a: assert property (
        (state_ff == swu_pkg::DELAY && cnt_ff == '0)
        |=> !lineTrueOut && !lineTrueOe_n ##1 txShift_ff[4:1] == swu_pkg::SYNC_BYTE[3:0] [*1])
        else $error("reply does not open with start and sync");

    // The bit time stays fixed while the reply delay runs.
    reply_rate_a: assert property (
        (state_ff == swu_pkg::DELAY) |=> $stable(bitTime_ff))
        else $error("bit time changed before reply");

    // Drivers are released once the tail has run out.
    tail_release_a: assert property (
        (state_ff == swu_pkg::TAIL && cnt_ff == '0) |=> lineTrueOe_n && lineCompOe_n)
        else $error("drivers held after tail");

    // A bad checksum is never acted upon.
    crc_reject_a: assert property (
        (state_ff == swu_pkg::RXBIT && cnt_ff == '0 && bitIdx_ff == swu_pkg::RX_STOP_IDX
         && rx && crcIdx && rxByte_ff != crc_ff) |=> state_ff == swu_pkg::RECOVER && !rdReq)
        else $error("bad checksum accepted");

endmodule

// ### single_wire_uart_slave_port_tb.sv
// Self-checking testbench of the single-wire UART slave port.
module single_wire_uart_slave_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 20;
    logic clk, rst, lineTrueOut, lineTrueOe_n, wrValid, wrReady, rdReq, hostOut, line, ok;
    logic lineCompOut, lineCompOe_n, incPin;
    logic [6:0] wrAddr, rdAddr;
    logic [31:0] wrData;
    logic [7:0] datagramCount, b, e[8];
    int miscompares, checked, n;
    // The line follows the device while it drives, otherwise the host.
    assign line = lineTrueOe_n ? hostOut : lineTrueOut;
    single_wire_uart_slave_port #(.DEF_BIT(16)) i_single_wire_uart_slave_port (.clk(clk), .rst(rst),
        .lineTrueIn(line), .lineTrueOut(lineTrueOut), .lineTrueOe_n(lineTrueOe_n), .lineCompOut(lineCompOut),
        .lineCompOe_n(lineCompOe_n), .nodeAddressSetting(8'h12), .addressIncrementPin(incPin),
        .replyDelaySetting(4'h2),
        .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData), .rdReq(rdReq),
        .rdAddr(rdAddr), .rdData(32'h89abcdef), .datagramCount(datagramCount));
    swu_host #(.T(T)) i_swu_host (.clk(clk), .lineIn(line), .lineOut(hostOut));
    // Compares one value and counts it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits, bounded, for write valid, read pulse or driver enable.
    task automatic poll(input int s);
        n = 0;
        while ((s == 0 ? wrValid : s == 1 ? rdReq : !lineTrueOe_n) !== 1'h1 && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask
    // A write to address setting plus one lands in the buffer and is counted.
    task automatic test_write;
        i_swu_host.send(8'h13, 8'h85, 32'h12345678, 1'h0);
        poll(0);
        check(wrValid, 1'h1);
        check(wrAddr, 7'h05);
        check(wrData, 32'h12345678);
        check(datagramCount, 8'h01);
        wrReady = 1'h1;
        @(negedge clk);
        wrReady = 1'h0;
        $display("write test done");
    endtask
    // Foreign address and bad checksum are both dropped; without the pin the plain setting answers.
    task automatic test_ignore;
        i_swu_host.send(8'h12, 8'h85, 32'h1, 1'h0);
        i_swu_host.send(8'h13, 8'h85, 32'h2, 1'h1);
        repeat (15 * T) @(negedge clk);
        check(wrValid, 1'h0);
        check(datagramCount, 8'h01);
        incPin = 1'h0;
        repeat (4) @(negedge clk);
        i_swu_host.send(8'h12, 8'h81, 32'h000000a5, 1'h0);
        poll(0);
        check(wrAddr, 7'h01);
        check(wrData, 32'h000000a5);
        check(datagramCount, 8'h02);
        wrReady = 1'h1;
        @(negedge clk);
        wrReady = 1'h0;
        incPin = 1'h1;
        $display("ignore test done");
    endtask
    // A read request gets a delayed, framed reply, then the drivers let go.
    task automatic test_read;
        e = '{8'h05, 8'hff, 8'h0a, 8'h89, 8'hab, 8'hcd, 8'hef, 8'h00};
        i_swu_host.crc = 8'h00;
        for (int i = 0; i < 7; i++) i_swu_host.fold(e[i]);
        e[7] = i_swu_host.crc;
        fork
            i_swu_host.send(8'h13, 8'h0a, 32'h0, 1'h0);
            begin
                // The request pulse falls inside the last stop bit, so it is watched during the send.
                repeat (38 * T) @(negedge clk);
                poll(1);
                check(rdReq, 1'h1);
                check(rdAddr, 7'h0a);
                poll(2);
                check(n >= 16 * T - 3 && n <= 16 * T + 3, 1'h1);
            end
        join
        for (int i = 0; i < 8; i++) begin
            i_swu_host.recvByte(b, ok);
            check(b, e[i]);
            check(ok, 1'h1);
        end
        repeat (3 * T) @(negedge clk);
        check(lineTrueOe_n, 1'h0);
        check(lineCompOe_n, 1'h0);
        check(lineCompOut, 1'h0);
        repeat (3 * T) @(negedge clk);
        check(lineTrueOe_n, 1'h1);
        check(lineCompOe_n, 1'h1);
        check(datagramCount, 8'h02);
        $display("read test done");
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Free-running clock.
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Watchdog well beyond the expected run length.
    initial begin
        #200us;
        miscompares++;
        close_out();
    end
    // Reset, then the scenarios in order.
    initial begin
        rst = 1'h1;
        wrReady = 1'h0;
        incPin = 1'h1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        repeat (5) @(negedge clk);
        test_write();
        test_ignore();
        test_read();
        close_out();
    end
endmodule

// ### swu_fifo.sv
// Parameterised FIFO with valid and ready on both sides.
module swu_fifo #(
    parameter int WIDTH = 39,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic push, pop;

    // Full when the pointers differ only in the wrap bit.
    assign inReady = (wp_ff ^ rp_ff) != {1'b1, {AW{1'b0}}};
    assign outValid = wp_ff != rp_ff;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rp_ff[AW-1:0]];

    // Pointers advance on each accepted push and pop.
    always_comb begin
        nxt_wp = wp_ff + PW'(push);
        nxt_rp = rp_ff + PW'(pop);
    end

    // Pointer registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
    end

    // Storage needs no reset; empty words are never read out.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_ff[AW-1:0]] <= inData;
        end
    end

endmodule

// ### swu_host.sv
// Host UART master model that drives and samples the shared line.
module swu_host #(
    parameter int T = 20
) (
    input wire logic clk,
    input wire logic lineIn,
    output logic lineOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] crc;
    initial lineOut = 1'h1;
    // Folds one byte into the running checksum, least significant bit first.
    task automatic fold(input logic [7:0] d);
        for (int i = 0; i < 8; i++) crc = (crc[7] ^ d[i]) ? ((crc << 1) ^ 8'h07) : (crc << 1);
    endtask
    // Sends one framed byte: low start bit, data LSB first, high stop bit.
    task automatic sendByte(input logic [7:0] d);
        fold(d);
        lineOut = 1'h0;
        repeat (T) @(negedge clk);
        for (int i = 0; i < 9; i++) begin
            lineOut = (i < 8) ? d[i] : 1'h1;
            repeat (T) @(negedge clk);
        end
    endtask
    // Sends a whole datagram; data bytes only go out for a write.
    task automatic send(input logic [7:0] a, input logic [7:0] r, input logic [31:0] d, input logic badCrc);
        crc = 8'h00;
        sendByte(8'h05);
        sendByte(a);
        sendByte(r);
        if (r[7]) for (int i = 3; i >= 0; i--) sendByte(d[8*i +: 8]);
        sendByte(crc ^ {7'h00, badCrc});
    endtask
    // Receives one byte, sampling each bit at its middle.
    task automatic recvByte(output logic [7:0] d, output logic stopOk);
        int n;
        n = 0;
        while (lineIn !== 1'h0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        repeat (T / 2 + T) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            d[i] = lineIn;
            repeat (T) @(negedge clk);
        end
        stopOk = lineIn;
    endtask
endmodule

// ### swu_pkg.sv
// Constants, states and checksum function of the single-wire UART slave port.
//
// Behaviour
// - Every datagram opens with sync nibble 1,0,1,0 in bits 0-3; upper nibble reserved.
// - Write datagram: sync, address, RW plus register, 32 data bits, CRC byte.
// - Each byte has a low start bit, LSB first data, high stop bit.
// - Bit time is measured from start-bit fall to the fall between sync bits 2 and 3.
// - Node address is the address setting, plus one when the increment pin is set.
// - Over 63 bit times between start bits abandons the datagram.
// - Pulses under 16 clocks on an idle line are glitches; then wait 12 idle bits.
// - Bad checksum or other errors discard the datagram and need 12 idle bits.
// - An 8-bit wrapping counter counts accepted writes only and is readable.
// - Read request: sync, address, RW plus register, CRC in bits 24-31.
// - Reply uses the baud rate measured on the read request.
// - Reply waits the delay setting times eight bit times, default eight.
// - Reply: sync with zero reserved bits, all-ones address, register, data, CRC.
// - Drivers release four bit times after the last reply bit.
// - All-ones address marks replies and is never a slave address.
// - Reply data is shifted from the live register without a snapshot.
// - CRC8 x^8+x^2+x+1, start zero, over all prior bytes, LSB first.
// - Only datagrams with good checksum and own address are acted upon.
// - Both line pins are inputs except while a reply is being sent and during its tail.
package swu_pkg;

    // Clock and baud limits.
    localparam int CLK_HZ = 100_000_000;
    localparam int MIN_BAUD = 9000;
    localparam int DEF_BAUD = 115200;
    localparam int MAX_BIT_CYCLES = CLK_HZ / MIN_BAUD;
    localparam int DEF_BIT_CYCLES = CLK_HZ / DEF_BAUD;
    localparam int MIN_BIT_CYCLES = 16;

    // Timing counts in bit times or clock cycles.
    localparam int GLITCH_CYCLES = 16;
    localparam int GAP_BITS = 63;
    localparam int RECOVER_BITS = 12;
    localparam int TAIL_BITS = 4;
    localparam int DELAY_UNIT_BITS = 8;
    localparam int MEAS_BITS = 4;

    // Framing and datagram layout.
    localparam logic [2:0] SYNC_LOW3 = 3'h5;
    localparam logic [7:0] SYNC_BYTE = 8'h05;
    localparam logic [7:0] REPLY_ADDR = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam int RW_BIT = 7;
    localparam logic [3:0] SYNC3_IDX = 4'h3;
    localparam logic [3:0] RX_STOP_IDX = 4'h8;
    localparam logic [3:0] TX_STOP_IDX = 4'h9;
    localparam logic [2:0] SHORT_CRC_IDX = 3'h3;
    localparam logic [2:0] LONG_CRC_IDX = 3'h7;
    localparam logic [2:0] ADDR_IDX = 3'h1;
    localparam logic [2:0] REG_IDX = 3'h2;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 39;

    // Controller states, Gray coded along the receive and reply path.
    typedef enum logic [3:0] {
        IDLE = 4'h0,
        MEAS = 4'h1,
        RXBIT = 4'h3,
        GAP = 4'h2,
        PUSH = 4'h6,
        DELAY = 4'h7,
        TXBIT = 4'h5,
        TAIL = 4'h4,
        RECOVER = 4'hc
    } state_t;

    // Folds one byte into the checksum, least significant bit first.
    function automatic logic [7:0] crcByte(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[7] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

endpackage
